// *** inc/lam_pkg.sv ***
// Package with constants and types for the link alarm monitor
package lam_pkg;
	localparam int ALM_COUNT   = 6;
	localparam int LANE_COUNT  = 8;
	// Alarm bit positions
	localparam int ALM_CPLL    = 0;
	localparam int ALM_SPLL    = 1;
	localparam int ALM_LINK    = 2;
	localparam int ALM_SYSREF  = 3;
	localparam int ALM_CLK     = 4;
	localparam int ALM_FIFO    = 5;
	localparam logic [5:0] ALARM_STATUS_BITS_RESET = 6'h00;
	localparam logic [5:0] ALARM_TYPE_MASK_RESET   = 6'h3f;
	localparam logic [7:0] LANE_FLAGS_RESET = 8'h00;
	// Local multiframe / extended multiblock counter
	localparam int MFC_W = 8;
	localparam logic [MFC_W-1:0] MFC_ZERO = 8'h00;
	localparam logic [MFC_W-1:0] MFC_ONE  = 8'h01;
	// Status pin selector codes
	localparam logic [1:0] PINSEL_ALARM = 2'h1;
	// Link bring-up states
	typedef enum logic [1:0] {LAM_OFF, LAM_CGS, LAM_ILAS, LAM_DATA} lam_link_state_t;
endpackage : lam_pkg

// *** rtl/lam_sticky.sv ***
// Sticky write-one-to-clear flag group
`timescale 1ns/10ps
`default_nettype none
module lam_sticky
	import lam_pkg::*;
#(
	parameter int W = 6
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] set_in,
	input  wire logic [W-1:0] clr_w1c,
	output logic      [W-1:0] flags_reg
);
	// Set beats clear so an event in the clearing cycle is kept
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					flags_reg[i] <= 1'b0;
				end else if (set_in[i]) begin
					flags_reg[i] <= 1'b1;
				end else if (clr_w1c[i]) begin
					flags_reg[i] <= 1'b0;
				end
			end
			AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_b)
				set_in[i] |=> flags_reg[i])
				else $error("sticky flag lost a set");
			AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
				(flags_reg[i] && !clr_w1c[i]) |=> flags_reg[i])
				else $error("sticky flag dropped without clear");
		end
	endgenerate
endmodule : lam_sticky
`default_nettype wire

// *** rtl/lam_monitor.sv ***
// Alarm monitor and local frame counter for the serial transmit side
// Functional notes
// - Six alarm sources: two PLL locks, link state, SYSREF realign, clock upset, FIFO.
// - Each alarm sets its own dedicated status bit.
// - Status bits stay set until host writes one to clear.
// - Unmasked alarms feed the summary alarm; masked ones do not.
// - Status pin driven high on alarm when selector picks alarm output.
// - Channel A and B clocks compared; a mismatch with both channels powered up sets clock upset flag.
// - Clock upset flag holds until host writes one.
// - Flag may be set after global power-down exit; host clears it.
// - Per-lane FIFO upset flag set when lane FIFO pointers disturbed.
// - Link enable low then high resets the lane FIFO logic.
// - Captured SYSREF resets local multiframe or extended multiblock counter.
// - Without SYSREF the counter free-runs with arbitrary phase.
// - In 8B/10B, SYNC request starts code group sync and lane alignment.
// - Link enable low holds link in reset, serializers off, clocks gated.
`timescale 1ns/10ps
`default_nettype none
module lam_monitor
	import lam_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  cpll_locked,
	input  wire logic                  spll_locked,
	input  wire logic                  sysref_realign,
	input  wire logic                  chan_a_clk_phase,
	input  wire logic                  chan_b_clk_phase,
	input  wire logic                  chan_a_powerdown,
	input  wire logic                  chan_b_powerdown,
	input  wire logic                  global_powerdown_pin,
	input  wire logic                  global_powerdown_mode,
	input  wire logic [LANE_COUNT-1:0] lane_fifo_ptr_err,
	input  wire logic [ALM_COUNT-1:0]  alarm_clear_w1c,
	input  wire logic [LANE_COUNT-1:0] lane_fifo_clear_w1c,
	input  wire logic [ALM_COUNT-1:0]  alarm_type_mask,
	input  wire logic [1:0]            cal_status_sel,
	input  wire logic                  cal_busy,
	input  wire logic                  link_enable,
	input  wire logic                  enc_64b66b,
	input  wire logic                  sysref_capture,
	input  wire logic                  sync_req_b,
	input  wire logic [MFC_W-1:0]      mfc_period_m1,
	output logic      [ALM_COUNT-1:0]  alarm_status_bits,
	output logic      [LANE_COUNT-1:0] lane_fifo_upset_flags,
	output logic                       clock_upset_flag,
	output logic                       summary_alarm,
	output logic                       cal_status_pin,
	output logic                       link_reset_b,
	output logic                       serializer_power_en,
	output logic                       serializer_clk_en,
	output logic                       lane_fifo_reset,
	output logic      [MFC_W-1:0]      mfc_count_reg,
	output logic                       mfc_edge_reg,
	output lam_link_state_t            link_state_reg
);
	logic [ALM_COUNT-1:0] alarm_set_next;
	logic                 link_enable_reg;
	logic                 gpd_reg;
	logic                 clk_mismatch;
	logic                 sync_req_reg;
	logic                 summary_alarm_reg;

	// Unmasked OR, reused for pin and summary
	function automatic logic masked_any(input logic [ALM_COUNT-1:0] st,
		input logic [ALM_COUNT-1:0] msk);
		masked_any = |(st & ~msk);
	endfunction : masked_any

	// Channel clock comparison; only meaningful with both channels up
	assign clk_mismatch = (chan_a_clk_phase != chan_b_clk_phase)
		&& !chan_a_powerdown && !chan_b_powerdown;

	// Alarm event sources
	always_comb begin
		alarm_set_next             = '0;
		alarm_set_next[ALM_CPLL]   = !cpll_locked;
		alarm_set_next[ALM_SPLL]   = !spll_locked;
		alarm_set_next[ALM_LINK]   = link_state_reg != LAM_DATA;
		alarm_set_next[ALM_SYSREF] = sysref_realign;
		// Leaving global power-down may disturb the compared clocks
		alarm_set_next[ALM_CLK]    = clk_mismatch
			|| (gpd_reg && !(global_powerdown_pin || global_powerdown_mode));
		alarm_set_next[ALM_FIFO]   = |lane_fifo_ptr_err;
	end

	// Group status flags
	lam_sticky #(.W(ALM_COUNT)) u_alarm_flags (
		.clk       (clk),
		.rst_b     (rst_b),
		.set_in    (alarm_set_next),
		.clr_w1c   (alarm_clear_w1c),
		.flags_reg (alarm_status_bits)
	);

	// Per-lane FIFO flags; only the host clears them, a link toggle resets just the FIFOs
	lam_sticky #(.W(LANE_COUNT)) u_lane_flags (
		.clk       (clk),
		.rst_b     (rst_b),
		.set_in    (lane_fifo_ptr_err),
		.clr_w1c   (lane_fifo_clear_w1c),
		.flags_reg (lane_fifo_upset_flags)
	);

	assign clock_upset_flag = alarm_status_bits[ALM_CLK];

	// Edge trackers for enable and power-down, plus the registered sync request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link_enable_reg <= 1'b0;
			gpd_reg         <= 1'b0;
			sync_req_reg    <= 1'b0;
		end else begin
			link_enable_reg <= link_enable;
			gpd_reg         <= global_powerdown_pin || global_powerdown_mode;
			sync_req_reg    <= !sync_req_b;
		end
	end

	// Link held off while disabled
	assign link_reset_b        = link_enable;
	assign serializer_power_en = link_enable;
	assign serializer_clk_en   = link_enable;
	// FIFO reset from the registered enable, starting one clock after the disable and ending one clock after the re-enable
	assign lane_fifo_reset     = !link_enable_reg;

	// Summary alarm registered, one clock behind status
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			summary_alarm_reg <= 1'b0;
		end else begin
			summary_alarm_reg <= masked_any(alarm_status_bits, alarm_type_mask);
		end
	end
	assign summary_alarm = summary_alarm_reg;

	// Pin shows alarm or calibration busy as selected
	assign cal_status_pin = (cal_status_sel == PINSEL_ALARM) ? summary_alarm_reg
		: cal_busy;

	// Local frame counter: SYSREF zeroes it, else free-runs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mfc_count_reg <= MFC_ZERO;
			mfc_edge_reg  <= 1'b0;
		end else if (sysref_capture) begin
			mfc_count_reg <= MFC_ZERO;
			mfc_edge_reg  <= 1'b1;
		end else if (mfc_count_reg >= mfc_period_m1) begin
			mfc_count_reg <= MFC_ZERO;
			mfc_edge_reg  <= 1'b1;
		end else begin
			mfc_count_reg <= mfc_count_reg + MFC_ONE;
			mfc_edge_reg  <= 1'b0;
		end
	end

	// Link bring-up: SYNC request drives code group sync then alignment
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link_state_reg <= LAM_OFF;
		end else if (!link_enable) begin
			link_state_reg <= LAM_OFF;
		end else begin
			unique case (link_state_reg)
				LAM_OFF: begin
					link_state_reg <= (enc_64b66b || !sync_req_reg) ? LAM_DATA : LAM_CGS;
				end
				LAM_CGS: begin
					if (!sync_req_reg && mfc_edge_reg)
						link_state_reg <= LAM_ILAS;
				end
				LAM_ILAS: begin
					if (sync_req_reg)
						link_state_reg <= LAM_CGS;
					else if (mfc_edge_reg)
						link_state_reg <= LAM_DATA;
				end
				LAM_DATA: begin
					if (sync_req_reg && !enc_64b66b)
						link_state_reg <= LAM_CGS;
				end
			endcase
		end
	end

	// Checks
	AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_b)
		masked_any(alarm_status_bits, alarm_type_mask) |=> summary_alarm)
		else $error("unmasked alarm missing from summary");
	AST_MASKED: assert property (@(posedge clk) disable iff (!rst_b)
		!masked_any(alarm_status_bits, alarm_type_mask) |=> !summary_alarm)
		else $error("summary set with no unmasked alarm");
	AST_PIN: assert property (@(posedge clk) disable iff (!rst_b)
		(cal_status_sel == PINSEL_ALARM) && masked_any(alarm_status_bits, alarm_type_mask)
			|=> (cal_status_sel != PINSEL_ALARM) || cal_status_pin)
		else $error("status pin low during alarm");
	AST_CLKUP: assert property (@(posedge clk) disable iff (!rst_b)
		clk_mismatch |=> clock_upset_flag)
		else $error("clock mismatch not flagged");
	AST_LINKOFF: assert property (@(posedge clk) disable iff (!rst_b)
		!link_enable |=> (link_state_reg == LAM_OFF) && lane_fifo_reset)
		else $error("link not held while disabled");
	AST_SYSREF: assert property (@(posedge clk) disable iff (!rst_b)
		sysref_capture |=> (mfc_count_reg == MFC_ZERO))
		else $error("sysref did not zero counter");
	AST_LANE: assert property (@(posedge clk) disable iff (!rst_b)
		lane_fifo_ptr_err[0] |=> lane_fifo_upset_flags[0]
			&& alarm_status_bits[ALM_FIFO])
		else $error("lane fifo upset not flagged");
	AST_SYNC: assert property (@(posedge clk) disable iff (!rst_b)
		(link_enable && !enc_64b66b && sync_req_reg && link_state_reg == LAM_DATA)
			|=> link_state_reg == LAM_CGS)
		else $error("sync request ignored");
	COV_ALARM: cover property (@(posedge clk) disable iff (!rst_b) $rose(summary_alarm));
	COV_DATA: cover property (@(posedge clk) disable iff (!rst_b)
		link_state_reg == LAM_ILAS ##1 link_state_reg == LAM_DATA);
	COV_CLR: cover property (@(posedge clk) disable iff (!rst_b) $fell(clock_upset_flag));
endmodule : lam_monitor
`default_nettype wire

// *** testbench/lam_rx_model.sv ***
// Behavioural receiver that requests link synchronisation
`timescale 1ns/10ps
`default_nettype none
module lam_rx_model
	import lam_pkg::*;
#(
	parameter int SYNC_HOLD = 4,
	parameter int RBD       = 2
) (
	input  wire logic            clk,
	input  wire logic            rst_b,
	input  wire lam_link_state_t link_state,
	input  wire logic            lmfc_edge,
	output var  logic            sync_req_b,
	output var  logic            buffers_released
);
	logic [3:0] hold_reg;
	logic [3:0] rbd_count_reg;
	logic       release_point;

	// Candidate release point in every LMFC/LEMC cycle, RBD frame clocks after the edge
	assign release_point = (rbd_count_reg == 4'(RBD));

	// Frame clocks since the last LMFC/LEMC edge, parked at the top when idle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rbd_count_reg <= 4'hf;
		end else if (lmfc_edge) begin
			rbd_count_reg <= 4'h0;
		end else if (rbd_count_reg != 4'hf) begin
			rbd_count_reg <= rbd_count_reg + 4'h1;
		end
	end

	// Data state stands for all lanes arrived; lane skew assumed inside one period
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			buffers_released <= 1'b0;
		end else if (link_state == LAM_OFF) begin
			buffers_released <= 1'b0;
		end else if (release_point && link_state == LAM_DATA) begin
			buffers_released <= 1'b1;
		end
	end

	// Request sync while idle, release after code groups settle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_reg   <= 4'h0;
			sync_req_b <= 1'b0;
		end else if (link_state == LAM_OFF) begin
			hold_reg   <= 4'h0;
			sync_req_b <= 1'b0;
		end else if (hold_reg != 4'(SYNC_HOLD)) begin
			hold_reg   <= hold_reg + 4'h1;
		end else begin
			sync_req_b <= 1'b1;
		end
	end
endmodule : lam_rx_model
`default_nettype wire

// *** testbench/link_alarm_monitor_sync_test.sv ***
// Self-checking bench for the alarm monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module link_alarm_monitor_sync_test;
	import lam_pkg::*;
	logic clk = 0, rst_b = 0, cpll_locked = 1, spll_locked = 1, sysref_realign = 0;
	logic chan_a_clk_phase = 0, chan_b_clk_phase = 0, chan_a_powerdown = 0;
	logic chan_b_powerdown = 0, global_powerdown_pin = 0, global_powerdown_mode = 0;
	logic [7:0] lane_fifo_ptr_err = 0, lane_fifo_clear_w1c = 0, lane_fifo_upset_flags;
	logic [5:0] alarm_clear_w1c = 0, alarm_type_mask = 6'h3f, alarm_status_bits;
	logic [1:0] cal_status_sel = 2'h1;
	logic cal_busy = 0, link_enable = 0, enc_64b66b = 0, sysref_capture = 0, sync_req_b;
	logic clock_upset_flag, summary_alarm, cal_status_pin, link_reset_b, lane_fifo_reset;
	logic serializer_power_en, serializer_clk_en, mfc_edge_reg, buffers_released;
	logic [7:0] mfc_count_reg;
	lam_link_state_t link_state_reg;
	int bad_count = 0, samples_checked = 0, cycles = 0;
	// Fast clock; inputs always move 1 ns after the edge to avoid races
	initial forever #2.5 clk = ~clk;
	lam_monitor DUT (.clk(clk), .rst_b(rst_b), .cpll_locked(cpll_locked),
		.spll_locked(spll_locked), .sysref_realign(sysref_realign),
		.chan_a_clk_phase(chan_a_clk_phase), .chan_b_clk_phase(chan_b_clk_phase),
		.chan_a_powerdown(chan_a_powerdown), .chan_b_powerdown(chan_b_powerdown),
		.global_powerdown_pin(global_powerdown_pin),
		.global_powerdown_mode(global_powerdown_mode), .lane_fifo_ptr_err(lane_fifo_ptr_err),
		.alarm_clear_w1c(alarm_clear_w1c), .lane_fifo_clear_w1c(lane_fifo_clear_w1c),
		.alarm_type_mask(alarm_type_mask), .cal_status_sel(cal_status_sel),
		.cal_busy(cal_busy), .link_enable(link_enable), .enc_64b66b(enc_64b66b),
		.sysref_capture(sysref_capture), .sync_req_b(sync_req_b), .mfc_period_m1(8'h07),
		.alarm_status_bits(alarm_status_bits), .lane_fifo_upset_flags(lane_fifo_upset_flags),
		.clock_upset_flag(clock_upset_flag), .summary_alarm(summary_alarm),
		.cal_status_pin(cal_status_pin), .link_reset_b(link_reset_b),
		.serializer_power_en(serializer_power_en), .serializer_clk_en(serializer_clk_en),
		.lane_fifo_reset(lane_fifo_reset), .mfc_count_reg(mfc_count_reg),
		.mfc_edge_reg(mfc_edge_reg), .link_state_reg(link_state_reg));
	lam_rx_model RX (.clk(clk), .rst_b(rst_b), .link_state(link_state_reg),
		.lmfc_edge(mfc_edge_reg), .sync_req_b(sync_req_b),
		.buffers_released(buffers_released));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// One-cycle alarm event on source i, then all sources back to quiet
	task automatic pulse_src(input int i);
		case (i)
			0: cpll_locked = 0;
			1: spll_locked = 0;
			3: sysref_realign = 1;
			4: chan_b_clk_phase = 1;
			5: lane_fifo_ptr_err = 8'h01;
			default: ;
		endcase
		tick(1);
		{cpll_locked, spll_locked, sysref_realign, chan_b_clk_phase} = 4'hc;
		lane_fifo_ptr_err = 8'h00;
		tick(1);
	endtask : pulse_src
	task automatic clear_all();
		alarm_clear_w1c = 6'h3f;
		lane_fifo_clear_w1c = 8'hff;
		tick(1);
		alarm_clear_w1c = 6'h00;
		lane_fifo_clear_w1c = 8'h00;
	endtask : clear_all
	// Bounded wait for the link to reach data transmission
	task automatic wait_data();
		for (int k = 0; k < 100 && link_state_reg !== LAM_DATA; k++) tick(1);
		`CHK(link_state_reg, LAM_DATA)
	endtask : wait_data
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	// Hang guard; whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		tick(16);
		rst_b = 1;
		tick(1);
		`CHK({lane_fifo_upset_flags, clock_upset_flag}, 9'h000)
		`CHK({link_reset_b, serializer_power_en, serializer_clk_en}, 3'h0)
		`CHK(lane_fifo_reset, 1'b1)
		`CHK(summary_alarm, 1'b0)
		// Each source except link state alone, unmasked only its own bit
		for (int i = 0; i < 6; i++) if (i != 2) begin
			alarm_type_mask = ~(6'h01 << i);
			pulse_src(i);
			`CHK(alarm_status_bits[i], 1'b1)
			`CHK(summary_alarm, 1'b1)
			`CHK(cal_status_pin, 1'b1)
			if (i == 5) `CHK(lane_fifo_upset_flags, 8'h01)
			tick(3);
			`CHK(alarm_status_bits[i], 1'b1)
			clear_all();
			`CHK(alarm_status_bits & 6'h3b, 6'h00)
			tick(1);
			`CHK(summary_alarm, 1'b0)
		end
		// Masked sysref alarm stays out of the summary until unmasked
		alarm_type_mask = 6'h0c;
		pulse_src(3);
		tick(1);
		`CHK({summary_alarm, alarm_status_bits[3]}, 2'h1)
		alarm_type_mask = 6'h04;
		tick(1);
		`CHK(summary_alarm, 1'b1)
		alarm_type_mask = 6'h3f;
		cal_status_sel = 2'h0;
		cal_busy = 1;
		tick(1);
		`CHK(cal_status_pin, 1'b1)
		clear_all();
		chan_a_powerdown = 1;
		pulse_src(4);
		`CHK(clock_upset_flag, 1'b0)
		chan_a_powerdown = 0;
		global_powerdown_mode = 1;
		tick(2);
		global_powerdown_mode = 0;
		tick(2);
		`CHK(clock_upset_flag, 1'b1)
		clear_all();
		`CHK(clock_upset_flag, 1'b0)
		tick(3);
		sysref_capture = 1;
		tick(1);
		sysref_capture = 0;
		`CHK({mfc_edge_reg, mfc_count_reg}, {1'b1, MFC_ZERO})
		tick(1);
		`CHK(mfc_count_reg, MFC_ONE)
		link_enable = 1;
		tick(1);
		`CHK({link_reset_b, serializer_power_en, serializer_clk_en}, 3'h7)
		`CHK(lane_fifo_reset, 1'b0)
		wait_data();
		`CHK(buffers_released, 1'b0)
		tick(1);
		clear_all();
		tick(1);
		`CHK(alarm_status_bits, 6'h00)
		// Link up, both channels powered, flag cleared: detection armed
		pulse_src(4);
		`CHK({clock_upset_flag, buffers_released}, 2'h3)
		link_enable = 0;
		tick(2);
		`CHK({lane_fifo_reset, alarm_status_bits[2], buffers_released}, 3'h6)
		enc_64b66b = 1;
		link_enable = 1;
		wait_data();
		// Release follows within one LEMC period plus the release delay
		tick(12);
		`CHK(buffers_released, 1'b1)
		complete_run();
	end
endmodule : link_alarm_monitor_sync_test
`default_nettype wire
